//--- design/ipdc_top.v
// Overview of operation
// - power-down stops the oscillator so no block gets any clock
// - idle gates only the cpu clock; interrupts, serial and timers keep running
// - control register sits at 87h and accepts byte access only
// - bit 7 doubles serial baud rate; bits 6 to 4 reserved
// - bits 3 and 2 are plain user flags without hardware effect
// - writing one to bit 1 starts power-down
// - writing one to bit 0 starts idle
// - both bits written together enter power-down, not idle
// - register reads zero in all defined bits after reset
// - idle-setting write is last instruction; cpu state is held during idle
// - an enabled interrupt clears idle bit and ends idle
// - hardware reset ends idle; it must be held 24 oscillator periods
// - power-down write is last instruction; registers and ram keep contents
// - hardware reset leaves power-down and restores register reset values
// - idle drives both strobes high; port states follow program memory source
// - power-down drives both strobes low; port two shows its latch
// - fully static logic tolerates clock slowed to zero
// - port latch zero turns pull-ups off and pull-down on
// - latch rise enables strong pull-up exactly two periods, then keeper holds; in power-down port two keeps latch ones on the strong pull-up throughout
// - port two address ones keep strong pull-up for whole access
`timescale 1ns/100ps
`default_nettype none

`include "ipdc_consts.vh"

module ipdc_top (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // hardware reset pin, active high
  input wire rst_pin_in,
  // special function register access from the core
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  input wire sfr_bit_op_in,
  input wire [7:0] sfr_wdata_in,
  output reg [7:0] sfr_rdata_out,
  output reg sfr_hit_out,
  // interrupt system
  input wire irq_enabled_pending_in,
  // program memory source, high when fetching externally
  input wire ext_prog_in,
  // strobes from the core
  input wire ale_core_in,
  input wire program_fetch_strobe_core_in,
  // port latches and address from the core
  input wire [7:0] p0_latch_in,
  input wire [7:0] p0_bus_in,
  input wire p0_bus_mode_in,
  input wire [7:0] p1_latch_in,
  input wire [7:0] port_two_latch_in,
  input wire [7:0] p2_addr_in,
  input wire p2_addr_mode_in,
  input wire [7:0] p3_latch_in,
  // clock gating
  output reg osc_run_out,
  output reg cpu_clk_en_out,
  output reg periph_clk_en_out,
  // mode status
  output reg idle_active_out,
  output reg powerdown_active_out,
  output reg baud_double_out,
  output reg internal_reset_out,
  // strobe pins
  output reg ale_out,
  output reg program_fetch_strobe_out,
  // port 0 open-drain pins
  output reg [7:0] p0_data_out,
  output reg [7:0] p0_oe_out,
  // ports 1 to 3 pin transistors
  output wire [7:0] p1_pull_down_out,
  output wire [7:0] p1_strong_pullup_out,
  output wire [7:0] p1_weak_keeper_out,
  output wire [7:0] p2_pull_down_out,
  output wire [7:0] p2_strong_pullup_out,
  output wire [7:0] p2_weak_keeper_out,
  output wire [7:0] p3_pull_down_out,
  output wire [7:0] p3_strong_pullup_out,
  output wire [7:0] p3_weak_keeper_out
);

  // ****************************************************************
  // reset release and pin synchronisers
  // ****************************************************************
  reg [1:0] rst_sync;
  wire rst_n;
  reg [1:0] rst_pin_sync;
  reg [1:0] irq_sync;
  reg [1:0] ext_sync;
  wire rst_pin_s;
  wire irq_s;
  wire ext_s;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_sync <= 2'h0;
      irq_sync <= 2'h0;
      ext_sync <= 2'h0;
    end else begin
      rst_pin_sync <= {rst_pin_sync[0], rst_pin_in};
      irq_sync <= {irq_sync[0], irq_enabled_pending_in};
      ext_sync <= {ext_sync[0], ext_prog_in};
    end
  end

  assign rst_pin_s = rst_pin_sync[1];
  assign irq_s = irq_sync[1];
  assign ext_s = ext_sync[1];

  // ****************************************************************
  // hardware reset pin qualification
  // ****************************************************************
  reg [`IPDC_RST_CNT_W-1:0] rst_cnt;
  reg hw_reset;
  wire rst_cnt_done;

  assign rst_cnt_done = (rst_cnt == (`IPDC_RESET_HOLD_CYCLES - 1));

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt <= {`IPDC_RST_CNT_W{1'b0}};
      hw_reset <= 1'b0;
    end else begin
      if (!rst_pin_s) begin
        rst_cnt <= {`IPDC_RST_CNT_W{1'b0}};
        hw_reset <= 1'b0;
      end else if (rst_cnt_done) begin
        hw_reset <= 1'b1;
      end else begin
        rst_cnt <= rst_cnt + 1'b1;
      end
    end
  end

  // ****************************************************************
  // power mode control register
  // ****************************************************************
  reg baud_double;
  reg user_flag_hi;
  reg user_flag_lo;
  reg powerdown_request;
  reg idle_request;
  wire pmc_sel;
  wire pmc_wr;
  wire wr_pd;
  wire wr_idle;

  function sel_pmc;
    input [7:0] addr;
    input bit_op;
    begin
      sel_pmc = (addr == `IPDC_PMC_ADDR) && !bit_op;
    end
  endfunction

  assign pmc_sel = sel_pmc(sfr_addr_in, sfr_bit_op_in);
  assign pmc_wr = sfr_wr_in && pmc_sel;
  assign wr_pd = pmc_wr && sfr_wdata_in[`IPDC_BIT_POWERDOWN];
  assign wr_idle = pmc_wr && sfr_wdata_in[`IPDC_BIT_IDLE] && !wr_pd;

  // register bits hold their values in both modes; the fabric is static
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      baud_double <= 1'b0;
      user_flag_hi <= 1'b0;
      user_flag_lo <= 1'b0;
      powerdown_request <= 1'b0;
      idle_request <= 1'b0;
    end else if (hw_reset) begin
      baud_double <= 1'b0;
      user_flag_hi <= 1'b0;
      user_flag_lo <= 1'b0;
      powerdown_request <= 1'b0;
      idle_request <= 1'b0;
    end else begin
      if (pmc_wr) begin
        baud_double <= sfr_wdata_in[`IPDC_BIT_BAUD_DOUBLE];
        user_flag_hi <= sfr_wdata_in[`IPDC_BIT_USER_FLAG_HI];
        user_flag_lo <= sfr_wdata_in[`IPDC_BIT_USER_FLAG_LO];
      end
      if (wr_pd) begin
        powerdown_request <= 1'b1;
      end
      // a fresh idle write wins over a same-cycle interrupt clear
      if (wr_idle) begin
        idle_request <= 1'b1;
      end else if (irq_s) begin
        idle_request <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_out <= 8'h00;
      sfr_hit_out <= 1'b0;
    end else begin
      sfr_hit_out <= (sfr_rd_in || sfr_wr_in) && pmc_sel;
      if (sfr_rd_in && pmc_sel) begin
        sfr_rdata_out <= {baud_double, `IPDC_RSVD_READ, user_flag_hi, user_flag_lo,
                          powerdown_request, idle_request};
      end else begin
        sfr_rdata_out <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // clock gating and mode status
  // ****************************************************************
  wire pd_now;
  wire idle_now;

  // the reset pin restarts the oscillator at once, ahead of qualification
  assign pd_now = powerdown_request && !rst_pin_s;
  assign idle_now = idle_request && !pd_now;

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      osc_run_out <= 1'b1;
      cpu_clk_en_out <= 1'b1;
      periph_clk_en_out <= 1'b1;
      idle_active_out <= 1'b0;
      powerdown_active_out <= 1'b0;
      baud_double_out <= 1'b0;
      internal_reset_out <= 1'b1;
    end else begin
      osc_run_out <= !pd_now;
      periph_clk_en_out <= !pd_now;
      // cpu stops right after the mode-setting write retires
      cpu_clk_en_out <= !(pd_now || idle_now || wr_pd || wr_idle);
      idle_active_out <= idle_now;
      powerdown_active_out <= pd_now;
      baud_double_out <= baud_double;
      internal_reset_out <= hw_reset;
    end
  end

  // ****************************************************************
  // strobe pins
  // ****************************************************************
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ale_out <= 1'b1;
      program_fetch_strobe_out <= 1'b1;
    end else if (pd_now) begin
      ale_out <= 1'b0;
      program_fetch_strobe_out <= 1'b0;
    end else if (idle_now) begin
      ale_out <= 1'b1;
      program_fetch_strobe_out <= 1'b1;
    end else begin
      ale_out <= ale_core_in;
      program_fetch_strobe_out <= program_fetch_strobe_core_in;
    end
  end

  // ****************************************************************
  // port 0 open drain
  // ****************************************************************
  wire low_power;

  assign low_power = pd_now || idle_now;

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      p0_data_out <= 8'h00;
      p0_oe_out <= 8'h00;
    end else if (low_power && ext_s) begin
      p0_data_out <= 8'h00;
      p0_oe_out <= 8'h00;
    end else if (p0_bus_mode_in && !low_power) begin
      p0_data_out <= p0_bus_in;
      p0_oe_out <= 8'hff;
    end else begin
      p0_data_out <= 8'h00;
      p0_oe_out <= ~p0_latch_in;
    end
  end

  // ****************************************************************
  // ports 1 to 3
  // ****************************************************************
  wire p2_use_addr;
  wire p2_strong_hold;
  wire [7:0] p2_level;
  wire [7:0] p1_level;
  wire [7:0] p3_level;

  // idle keeps the external address; power-down falls back to the latch
  assign p2_use_addr = pd_now ? 1'b0 : (idle_now ? ext_s : p2_addr_mode_in);
  // power-down keeps latch ones on the strong pull-up, not just the keeper
  assign p2_strong_hold = p2_use_addr || pd_now;
  assign p2_level = hw_reset ? 8'hff : (p2_use_addr ? p2_addr_in : port_two_latch_in);
  assign p1_level = hw_reset ? 8'hff : p1_latch_in;
  assign p3_level = hw_reset ? 8'hff : p3_latch_in;

  ipdc_port_drive u_port1 (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .level_in(p1_level),
    .addr_mode_in(1'b0),
    .pull_down_out(p1_pull_down_out),
    .strong_pullup_out(p1_strong_pullup_out),
    .weak_keeper_out(p1_weak_keeper_out)
  );

  ipdc_port_drive u_port2 (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .level_in(p2_level),
    .addr_mode_in(p2_strong_hold),
    .pull_down_out(p2_pull_down_out),
    .strong_pullup_out(p2_strong_pullup_out),
    .weak_keeper_out(p2_weak_keeper_out)
  );

  ipdc_port_drive u_port3 (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .level_in(p3_level),
    .addr_mode_in(1'b0),
    .pull_down_out(p3_pull_down_out),
    .strong_pullup_out(p3_strong_pullup_out),
    .weak_keeper_out(p3_weak_keeper_out)
  );

  // all state is in edge flops with no refresh or timeout, so the clock
  // may stop or single-step at any point

endmodule // ipdc_top

`default_nettype wire

//--- design/ipdc_consts.vh
`ifndef IPDC_CONSTS_VH
`define IPDC_CONSTS_VH

// ****************************************************************
// power mode control register
// ****************************************************************
`define IPDC_PMC_ADDR 8'h87
`define IPDC_PMC_RESET 8'h00
`define IPDC_BIT_BAUD_DOUBLE 7
`define IPDC_BIT_USER_FLAG_HI 3
`define IPDC_BIT_USER_FLAG_LO 2
`define IPDC_BIT_POWERDOWN 1
`define IPDC_BIT_IDLE 0
`define IPDC_RSVD_READ 3'h0

// ****************************************************************
// timing
// ****************************************************************
`define IPDC_OSC_PER_MACHINE_CYCLE 12
`define IPDC_RESET_MACHINE_CYCLES 2
`define IPDC_RESET_HOLD_CYCLES (`IPDC_OSC_PER_MACHINE_CYCLE * `IPDC_RESET_MACHINE_CYCLES)
`define IPDC_RST_CNT_W 5
`define IPDC_STRONG_PULLUP_PERIODS 2

`endif

//--- design/ipdc_port_drive.v
`timescale 1ns/100ps
`default_nettype none

`include "ipdc_consts.vh"

// ****************************************************************
// quasi-bidirectional port driver, one byte
// ****************************************************************
module ipdc_port_drive (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // port level and address mode
  input wire [7:0] level_in,
  input wire addr_mode_in,
  // pin transistors
  output reg [7:0] pull_down_out,
  output reg [7:0] strong_pullup_out,
  output reg [7:0] weak_keeper_out
);

  reg [7:0] prev_level;
  reg [7:0] pullup_first;
  wire [7:0] rise;

  assign rise = level_in & ~prev_level;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_level <= 8'hff;
      pullup_first <= 8'h00;
      pull_down_out <= 8'h00;
      strong_pullup_out <= 8'h00;
      weak_keeper_out <= 8'hff;
    end else begin
      prev_level <= level_in;
      // strong pullup held for two oscillator periods after a rise
      pullup_first <= addr_mode_in ? 8'h00 : rise;
      pull_down_out <= ~level_in;
      if (addr_mode_in) begin
        strong_pullup_out <= level_in;
      end else begin
        strong_pullup_out <= rise | (pullup_first & level_in);
      end
      weak_keeper_out <= level_in;
    end
  end

endmodule // ipdc_port_drive

`default_nettype wire

//--- tb/ipdc_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "ipdc_consts.vh"
// ****************************************
// power mode checks
// ****************************************
module ipdc_top_properties (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // register access
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic sfr_bit_op_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_hit_out,
  // events and ports
  input wire logic irq_enabled_pending_in,
  input wire logic rst_pin_in,
  input wire logic [7:0] p1_latch_in,
  input wire logic [7:0] p1_pull_down_out,
  input wire logic [7:0] p1_strong_pullup_out,
  // modes and strobes
  input wire logic osc_run_out,
  input wire logic cpu_clk_en_out,
  input wire logic periph_clk_en_out,
  input wire logic idle_active_out,
  input wire logic powerdown_active_out,
  input wire logic internal_reset_out,
  input wire logic ale_out,
  input wire logic program_fetch_strobe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire acc = (sfr_wr_in | sfr_rd_in) & (sfr_addr_in == `IPDC_PMC_ADDR) & ~sfr_bit_op_in;
  wire wr_ok = acc & sfr_wr_in & ~internal_reset_out & ~rst_pin_in;
  a_hit_byte: assert property (acc |=> sfr_hit_out) else $error("byte access not taken");
  a_hit_refused: assert property (!acc |=> !sfr_hit_out) else $error("refused access taken");
  a_idle_entry: assert property (wr_ok && sfr_wdata_in[1:0] == 2'h1 |=> ##1 idle_active_out && !cpu_clk_en_out)
    else $error("idle not entered");
  a_pd_wins: assert property (wr_ok && sfr_wdata_in[1] |=> ##1 powerdown_active_out && !idle_active_out)
    else $error("power-down not entered");
  a_pd_osc_stop: assert property ($rose(powerdown_active_out) |-> !osc_run_out && !periph_clk_en_out)
    else $error("clock runs in power-down");
  a_idle_clocks: assert property (idle_active_out |-> osc_run_out && periph_clk_en_out && !cpu_clk_en_out)
    else $error("wrong idle gating");
  a_idle_strobes: assert property (idle_active_out && $past(idle_active_out) |-> ale_out && program_fetch_strobe_out)
    else $error("idle strobes not high");
  a_pd_strobes: assert property (powerdown_active_out && $past(powerdown_active_out) && !osc_run_out
    |-> !ale_out && !program_fetch_strobe_out) else $error("power-down strobes not low");
  a_irq_wake: assert property ($rose(irq_enabled_pending_in) && idle_active_out && !sfr_wr_in
    |-> ##[3:5] !idle_active_out && cpu_clk_en_out) else $error("interrupt did not end idle");
  a_pullup_pulse: assert property ($rose(p1_latch_in[0]) && !internal_reset_out
    |=> p1_strong_pullup_out[0] [*2] ##1 !p1_strong_pullup_out[0]) else $error("strong pull-up pulse wrong");
  a_zero_pulldown: assert property (!p1_latch_in[0] && !internal_reset_out && !rst_pin_in
    |=> (p1_pull_down_out[0] && !p1_strong_pullup_out[0]) || internal_reset_out) else $error("zero not pulled down");
  c_wake: cover property (idle_active_out ##1 !idle_active_out);
  c_pd: cover property ($rose(powerdown_active_out));
  c_pulse: cover property ($rose(p1_strong_pullup_out[0]));
endmodule // ipdc_top_properties
`default_nettype wire

//--- tb/ipdc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// core, interrupt and reset source model
// ****************************************
module ipdc_core_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // bench commands and block status
  input wire logic irq_req_in,
  input wire logic rst_hold_in,
  input wire logic osc_run_in,
  input wire logic idle_in,
  // towards the block
  output logic irq_out,
  output logic rst_pin_out,
  output logic ale_out,
  output logic fetch_out
);
  logic [2:0] cnt;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 3'h0;
      irq_out <= 1'h0;
      rst_pin_out <= 1'h0;
      ale_out <= 1'h1;
      fetch_out <= 1'h1;
    end else begin
      cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
      ale_out <= (cnt == 3'h0);
      fetch_out <= (cnt != 3'h3);
      // request stays pending until the core wakes
      irq_out <= irq_req_in | (irq_out & idle_in);
      // reset kept on until the oscillator runs again
      rst_pin_out <= rst_hold_in | (rst_pin_out & ~osc_run_in);
    end
  end
endmodule // ipdc_core_model
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ipdc_consts.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
// ****************************************
// power mode bench
// ****************************************
module tb;
  logic clk_in = '0, rstn_in = '0, sfr_wr_in = '0, sfr_rd_in = '0, sfr_bit_op_in = '0, ext_prog_in = '0;
  logic p0_bus_mode_in = '0, p2_addr_mode_in = '0, irq_req = '0, rst_hold = '0;
  logic [7:0] sfr_addr_in = '0, sfr_wdata_in = '0, p0_latch_in = '0, p0_bus_in = '0, p1_latch_in = '0;
  logic [7:0] port_two_latch_in = '0, p2_addr_in = '0, p3_latch_in = 8'hff;
  logic rst_pin_in, irq_enabled_pending_in, ale_core_in, program_fetch_strobe_core_in;
  logic sfr_hit_out, osc_run_out, cpu_clk_en_out, periph_clk_en_out, idle_active_out, powerdown_active_out;
  logic baud_double_out, internal_reset_out, ale_out, program_fetch_strobe_out;
  logic [7:0] sfr_rdata_out, p0_data_out, p0_oe_out, p1_pull_down_out, p1_strong_pullup_out, p1_weak_keeper_out;
  logic [7:0] p2_pull_down_out, p2_strong_pullup_out, p2_weak_keeper_out;
  logic [7:0] p3_pull_down_out, p3_strong_pullup_out, p3_weak_keeper_out;
  int num_errors = 0;
  int n_tests = 0;
  ipdc_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .rst_pin_in(rst_pin_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_bit_op_in(sfr_bit_op_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .sfr_hit_out(sfr_hit_out), .irq_enabled_pending_in(irq_enabled_pending_in),
    .ext_prog_in(ext_prog_in), .ale_core_in(ale_core_in), .program_fetch_strobe_core_in(program_fetch_strobe_core_in),
    .p0_latch_in(p0_latch_in), .p0_bus_in(p0_bus_in), .p0_bus_mode_in(p0_bus_mode_in), .p1_latch_in(p1_latch_in),
    .port_two_latch_in(port_two_latch_in), .p2_addr_in(p2_addr_in), .p2_addr_mode_in(p2_addr_mode_in),
    .p3_latch_in(p3_latch_in), .osc_run_out(osc_run_out), .cpu_clk_en_out(cpu_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out), .idle_active_out(idle_active_out),
    .powerdown_active_out(powerdown_active_out), .baud_double_out(baud_double_out),
    .internal_reset_out(internal_reset_out), .ale_out(ale_out), .program_fetch_strobe_out(program_fetch_strobe_out),
    .p0_data_out(p0_data_out), .p0_oe_out(p0_oe_out), .p1_pull_down_out(p1_pull_down_out),
    .p1_strong_pullup_out(p1_strong_pullup_out), .p1_weak_keeper_out(p1_weak_keeper_out),
    .p2_pull_down_out(p2_pull_down_out), .p2_strong_pullup_out(p2_strong_pullup_out),
    .p2_weak_keeper_out(p2_weak_keeper_out), .p3_pull_down_out(p3_pull_down_out),
    .p3_strong_pullup_out(p3_strong_pullup_out), .p3_weak_keeper_out(p3_weak_keeper_out));
  ipdc_core_model u_core (.clk_in(clk_in), .rstn_in(rstn_in), .irq_req_in(irq_req), .rst_hold_in(rst_hold),
    .osc_run_in(osc_run_out), .idle_in(idle_active_out), .irq_out(irq_enabled_pending_in),
    .rst_pin_out(rst_pin_in), .ale_out(ale_core_in), .fetch_out(program_fetch_strobe_core_in));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_bit_op_in <= b;
    sfr_wr_in <= '1;
    tick(1);
    sfr_wr_in <= '0;
    sfr_bit_op_in <= '0;
    `CHK(sfr_hit_out, (a == `IPDC_PMC_ADDR) && !b)
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= '1;
    tick(1);
    sfr_rd_in <= '0;
    `CHK(sfr_rdata_out, e)
  endtask
  // reset pin held for n cycles, then time to settle
  task automatic pin(input int n);
    rst_hold <= '1;
    tick(n);
    // pin status lags the hold four edges: model, two syncs, status flop
    `CHK(internal_reset_out, n >= `IPDC_RESET_HOLD_CYCLES + 4)
    rst_hold <= '0;
    tick(6);
  endtask
  task automatic wait_wake;
    int i;
    for (i = 0; i < 16 && idle_active_out !== 1'h0; i++) tick(1);
    if (i == 16) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic summarize;
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    tick(6);
    rstn_in <= '1;
    tick(3);
    rd(`IPDC_PMC_ADDR, 8'h00);
    wr(`IPDC_PMC_ADDR, 8'hfc, '0);
    rd(`IPDC_PMC_ADDR, 8'h8c);
    `CHK(baud_double_out, 1'h1)
    wr(`IPDC_PMC_ADDR, 8'h00, '1);
    wr(8'h88, 8'h00, '0);
    rd(`IPDC_PMC_ADDR, 8'h8c);
    rd(8'h88, 8'h00);
    // idle while running from external program memory
    ext_prog_in <= '1;
    p2_addr_mode_in <= '1;
    p2_addr_in <= 8'ha5;
    p0_bus_mode_in <= '1;
    p0_bus_in <= 8'h5a;
    wr(`IPDC_PMC_ADDR, 8'h05, '0);
    `CHK({p0_data_out, p0_oe_out}, 16'h5aff)
    tick(1);
    `CHK({idle_active_out, cpu_clk_en_out, periph_clk_en_out, osc_run_out}, 4'hb)
    tick(1);
    `CHK({ale_out, program_fetch_strobe_out}, 2'h3)
    `CHK({p0_data_out, p0_oe_out}, 16'h0000)
    `CHK(p2_strong_pullup_out, 8'ha5)
    irq_req <= '1;
    wait_wake();
    irq_req <= '0;
    `CHK(cpu_clk_en_out, 1'h1)
    rd(`IPDC_PMC_ADDR, 8'h04);
    // idle from internal memory, ended by reset pin
    ext_prog_in <= '0;
    p2_addr_mode_in <= '0;
    p0_bus_mode_in <= '0;
    p0_latch_in <= 8'h0f;
    wr(`IPDC_PMC_ADDR, 8'h01, '0);
    tick(3);
    `CHK(p0_oe_out, 8'hf0)
    pin(20);
    `CHK(idle_active_out, 1'h1)
    pin(30);
    `CHK(idle_active_out, 1'h0)
    // power-down from external memory, both mode bits set
    ext_prog_in <= '1;
    p2_addr_mode_in <= '1;
    port_two_latch_in <= 8'h3c;
    wr(`IPDC_PMC_ADDR, 8'h8f, '0);
    tick(1);
    `CHK({powerdown_active_out, idle_active_out, osc_run_out, periph_clk_en_out, baud_double_out}, 5'h11)
    tick(2);
    `CHK({ale_out, program_fetch_strobe_out, p0_oe_out}, 10'h000)
    `CHK({p2_strong_pullup_out, baud_double_out}, 9'h079)
    `CHK({p2_pull_down_out, p2_weak_keeper_out}, 16'hc33c)
    pin(30);
    `CHK({powerdown_active_out, osc_run_out}, 2'h1)
    rd(`IPDC_PMC_ADDR, 8'h00);
    // port 1 pull-down and pull-up pulse
    p1_latch_in <= 8'h00;
    tick(2);
    `CHK({p1_pull_down_out, p1_strong_pullup_out}, 16'hff00)
    p1_latch_in <= 8'hff;
    tick(1);
    `CHK({p1_pull_down_out, p1_strong_pullup_out, p1_weak_keeper_out}, 24'h00ffff)
    tick(1);
    `CHK(p1_strong_pullup_out, 8'hff)
    tick(1);
    `CHK({p1_strong_pullup_out, p1_weak_keeper_out}, 16'h00ff)
    `CHK({p3_pull_down_out, p3_strong_pullup_out, p3_weak_keeper_out}, 24'h0000ff)
    summarize();
  end
endmodule // tb
bind ipdc_top ipdc_top_properties u_props (.clk_in(clk_in), .rstn_in(rstn_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_bit_op_in(sfr_bit_op_in), .sfr_wdata_in(sfr_wdata_in),
  .sfr_hit_out(sfr_hit_out), .irq_enabled_pending_in(irq_enabled_pending_in), .rst_pin_in(rst_pin_in),
  .p1_latch_in(p1_latch_in), .p1_pull_down_out(p1_pull_down_out), .p1_strong_pullup_out(p1_strong_pullup_out),
  .osc_run_out(osc_run_out), .cpu_clk_en_out(cpu_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
  .idle_active_out(idle_active_out), .powerdown_active_out(powerdown_active_out),
  .internal_reset_out(internal_reset_out), .ale_out(ale_out), .program_fetch_strobe_out(program_fetch_strobe_out));
`default_nettype wire
